// >>> verilog/ipc_pkg.sv
/*
 * constants, types and field layout for the interrupt controller host port.
 * assumes one 25 MHz clock; every pin reaches the logic through a
 * two-flop synchroniser before it is read.
 */
`default_nettype none
package ipc_pkg;
    // ======================================================================
    // port offsets and command decode
    localparam logic       PORT_LOW       = 1'b0;
    localparam logic       PORT_HIGH      = 1'b1;
    localparam int         CMD_SEL_BIT    = 4;   // 1: init_word_one
    localparam int         CMD_KIND_BIT   = 3;   // 1: read_select_cmd
    localparam logic [7:0] CALL_OPCODE    = 8'hCD;
    localparam logic [2:0] DEFAULT_LEVEL  = 3'h7;
    // ======================================================================
    // init_word_one fields
    localparam int         IW1_NEED_FOUR  = 0;
    localparam int         IW1_SINGLE     = 1;
    localparam int         IW1_STEP_FOUR  = 2;
    localparam int         IW1_LEVEL_TRIG = 3;
    // init_word_four fields
    localparam int         IW4_WIDE_HOST  = 0;
    localparam int         IW4_AUTO_END   = 1;
    localparam int         IW4_MASTER     = 2;
    localparam int         IW4_BUFFERED   = 3;
    // service_end_priority_cmd and read_select_cmd fields
    localparam int         SE_END_BIT     = 5;
    localparam int         SE_SPECIFIC    = 6;
    localparam int         RS_READ_ACT    = 1;
    localparam int         RS_IN_SERVICE  = 0;
    localparam int         RS_POLL        = 2;
    // ======================================================================
    // reset values
    localparam logic [7:0] WORD_RESET     = 8'h00;
    localparam logic [2:0] SEL_RESET      = 3'h0;
    localparam logic [1:0] STEP_RESET     = 2'h0;
    localparam logic [1:0] LAST_STEP_WIDE = 2'h1;
    localparam logic [1:0] LAST_STEP_NARR = 2'h2;
    localparam int         SYNC_STAGES    = 2;

    // ======================================================================
    // types
    typedef enum logic [3:0] {
        INIT_READY = 4'b0001,
        WAIT_TWO   = 4'b0010,
        WAIT_THREE = 4'b0100,
        WAIT_FOUR  = 4'b1000
    } ipcInitSt_t;

    typedef struct packed {
        logic       chipSelectN;
        logic       readN;
        logic       writeN;
        logic       portSelect;
        logic       cpuAckN;
        logic [7:0] hostDataIn;
    } ipcHostPins_t;

    typedef struct packed {
        ipcHostPins_t host;
        logic [7:0]   serviceReqLine;
        logic [2:0]   chainIdIn;
        logic         roleIn;
    } ipcPinsIn_t;

    // idle pin levels: strobes high, request lines pulled up, role master;
    // the syncs reset to these so no false strobe edge follows reset
    localparam ipcPinsIn_t PINS_IDLE = 25'h1D00FF1;
endpackage
`default_nettype wire

// >>> verilog/ipc_sync.sv
/*
 * two-flop synchroniser for a bundle of pin inputs.
 * assumes inputs are asynchronous to ref_clk; only stage two is read.
 */
`default_nettype none
`timescale 1ns/1ps
module ipc_sync #(
    parameter int               WIDTH = 1,
    parameter logic [WIDTH-1:0] IDLE  = '0
) (
    input  wire logic             ref_clk,
    input  wire logic             nrst,
    input  wire logic [WIDTH-1:0] pinIn,
    output logic      [WIDTH-1:0] pinSync
);
    import ipc_pkg::*;
    logic [WIDTH-1:0] stageOne_q;
    logic [WIDTH-1:0] stageTwo_q;

    // ======================================================================
    // stage one feeds stage two only, to settle metastability
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            stageOne_q <= IDLE;   // idle level, not zero: avoids fake edges
            stageTwo_q <= IDLE;
        end else begin
            stageOne_q <= pinIn;
            stageTwo_q <= stageOne_q;
        end
    end
    assign pinSync = stageTwo_q;
endmodule // ipc_sync
`default_nettype wire

// >>> verilog/ipc_resolver.sv
/*
 * fixed priority resolver: level zero highest, a level is blocked by any
 * in-service level of equal or higher priority.
 * assumes registered inputs on the same clock; purely combinational.
 */
`default_nettype none
`timescale 1ns/1ps
module ipc_resolver (
    input  wire logic [7:0] pending,
    input  wire logic [7:0] masked,
    input  wire logic [7:0] inService,
    output logic            reqValid,
    output logic      [2:0] reqLevel,
    output logic      [2:0] topService
);
    import ipc_pkg::*;
    logic [8:0] svcSeen;
    logic [8:0] reqSeen;
    logic [7:0] cand;
    logic [7:0] pick;
    logic [7:0] svcPick;

    assign svcSeen[0] = 1'b0;
    assign reqSeen[0] = 1'b0;
    // ======================================================================
    // per level: blocked by in-service at or above, first candidate wins
    for (genvar i = 0; i < 8; i++) begin : gLevel
        assign svcPick[i]   = inService[i] & ~svcSeen[i];
        assign svcSeen[i+1] = svcSeen[i] | inService[i];
        assign cand[i]      = pending[i] & ~masked[i] & ~svcSeen[i+1];
        assign pick[i]      = cand[i] & ~reqSeen[i];
        assign reqSeen[i+1] = reqSeen[i] | cand[i];
    end

    // ======================================================================
    // encode the one-hot picks
    always_comb begin
        reqLevel   = 3'h0;
        topService = 3'h0;
        for (int k = 0; k < 8; k++) begin
            if (pick[k]) begin
                reqLevel = 3'(k);
            end
            if (svcPick[k]) begin
                topService = 3'(k);
            end
        end
        reqValid = reqSeen[8];
    end
endmodule // ipc_resolver
`default_nettype wire

// >>> verilog/ipc_top.sv
/*
 * host port, request capture and acknowledge sequencer of an eight-level
 * interrupt controller.
 * assumes every pin is asynchronous to ref_clk; strobes must stay low
 * several clock periods so that their edges are seen after the syncs.
 */
`default_nettype none
`timescale 1ns/1ps
module ipc_top (
    input  wire logic                 ref_clk,
    input  wire logic                 nrst,
    input  wire ipc_pkg::ipcHostPins_t hostPins,
    input  wire logic [7:0]           serviceReqLine,
    input  wire logic [2:0]           chainIdIn,
    input  wire logic                 roleIn,
    output logic      [7:0]           hostDataOut,
    output logic                      hostDataOe,
    output logic                      cpuAlertOut,
    output logic      [2:0]           chainIdOut,
    output logic                      chainIdOe,
    output logic                      roleOut,
    output logic                      roleOe
);
    import ipc_pkg::*;

    // ======================================================================
    // synchronised pins
    ipcPinsIn_t pinRaw;
    ipcPinsIn_t pinNow;
    assign pinRaw = '{host: hostPins, serviceReqLine: serviceReqLine,
                      chainIdIn: chainIdIn, roleIn: roleIn};

    ipc_sync #(
        .WIDTH   ($bits(ipcPinsIn_t)),
        .IDLE    (PINS_IDLE)
    ) uSync (
        .ref_clk (ref_clk),
        .nrst    (nrst),
        .pinIn   (pinRaw),
        .pinSync (pinNow)
    );

    // ======================================================================
    // state
    ipcInitSt_t initSt_q,    initSt_d;
    logic [7:0] wordOne_q,   wordOne_d;
    logic [7:0] wordTwo_q,   wordTwo_d;
    logic [7:0] wordThree_q, wordThree_d;
    logic [7:0] wordFour_q,  wordFour_d;
    logic [7:0] maskReg_q,   maskReg_d;
    logic [7:0] pendReg_q,   pendReg_d;
    logic [7:0] svcReg_q,    svcReg_d;
    logic [2:0] readSel_q,   readSel_d;
    logic [1:0] ackStep_q,   ackStep_d;
    logic [2:0] ackLevel_q,  ackLevel_d;
    logic       ackOwned_q,  ackOwned_d;
    logic [7:0] reqPrev_q;
    logic       ackPrev_q;
    logic       readPrev_q;
    logic       writePrev_q;
    logic [7:0] dataOut_q,   dataOut_d;
    logic       dataOe_q,    dataOe_d;
    logic       alert_q,     alert_d;
    logic [2:0] casOut_q,    casOut_d;
    logic       casOe_q,     casOe_d;
    logic       roleOut_q,   roleOut_d;
    logic       roleOe_q,    roleOe_d;

    // ======================================================================
    // decoded conditions
    logic       reqValid;
    logic [2:0] reqLevel;
    logic [2:0] topService;
    logic       ackLow;
    logic       ackFall;
    logic       ackRise;
    logic       readLow;
    logic       readRise;
    logic       writeRise;
    logic       isMaster;
    logic       single;
    logic       wideHost;
    logic       buffered;
    logic [1:0] lastStep;
    logic       addrMatch;
    logic       slaveAtLevel;
    logic [7:0] reqSet;

    ipc_resolver uResolve (
        .pending    (pendReg_q),
        .masked     (maskReg_q),
        .inService  (svcReg_q),
        .reqValid   (reqValid),
        .reqLevel   (reqLevel),
        .topService (topService)
    );

    // strobe edges; chip select only qualifies read and write
    assign ackLow    = ~pinNow.host.cpuAckN;
    assign ackFall   = ackLow & ackPrev_q;
    assign ackRise   = ~ackLow & ~ackPrev_q;
    assign readLow   = ~pinNow.host.readN & ~pinNow.host.chipSelectN
                       & pinNow.host.writeN;
    // the other strobe must have been high a cycle too, so a prohibited
    // overlap released on one edge is neither a read nor a write
    assign readRise  = pinNow.host.readN & ~readPrev_q
                       & ~pinNow.host.chipSelectN & writePrev_q;
    assign writeRise = pinNow.host.writeN & ~writePrev_q
                       & ~pinNow.host.chipSelectN
                       & pinNow.host.readN & readPrev_q;
    assign buffered  = wordFour_q[IW4_BUFFERED];
    assign single    = wordOne_q[IW1_SINGLE];
    assign wideHost  = wordFour_q[IW4_WIDE_HOST];
    assign isMaster  = buffered ? wordFour_q[IW4_MASTER]
                                : pinNow.roleIn;
    assign lastStep  = wideHost ? LAST_STEP_WIDE : LAST_STEP_NARR;
    assign addrMatch = (pinNow.chainIdIn == wordThree_q[2:0]);
    assign slaveAtLevel = ~single & isMaster & wordThree_q[ackLevel_q];

    // edge mode takes fresh rises only; level mode takes any high level
    assign reqSet = wordOne_q[IW1_LEVEL_TRIG]
                    ? pinNow.serviceReqLine
                    : pinNow.serviceReqLine & ~reqPrev_q;

    // ======================================================================
    // command words, mask, pending, in-service and acknowledge sequence
    always_comb begin
        logic [7:0] pendClr;
        logic [7:0] svcSet;
        logic [7:0] svcClr;
        logic [7:0] wData;
        pendClr     = 8'h00;
        svcSet      = 8'h00;
        svcClr      = 8'h00;
        wData       = pinNow.host.hostDataIn;
        initSt_d    = initSt_q;
        wordOne_d   = wordOne_q;
        wordTwo_d   = wordTwo_q;
        wordThree_d = wordThree_q;
        wordFour_d  = wordFour_q;
        maskReg_d   = maskReg_q;
        readSel_d   = readSel_q;
        ackStep_d   = ackStep_q;
        ackLevel_d  = ackLevel_q;
        ackOwned_d  = ackOwned_q;

        // port zero writes: bit four picks init, bit three picks kind
        if (writeRise && pinNow.host.portSelect == PORT_LOW) begin
            if (wData[CMD_SEL_BIT]) begin
                wordOne_d  = wData;
                wordFour_d = WORD_RESET;  // defaults unless word four follows
                maskReg_d  = WORD_RESET;
                readSel_d  = SEL_RESET;
                initSt_d   = WAIT_TWO;
            end else if (wData[CMD_KIND_BIT]) begin
                if (wData[RS_READ_ACT]) begin
                    readSel_d[RS_IN_SERVICE] = wData[RS_IN_SERVICE];
                end
                readSel_d[RS_POLL] = wData[RS_POLL];
            end else if (wData[SE_END_BIT]) begin
                svcClr[wData[SE_SPECIFIC] ? wData[2:0] : topService] = 1'b1;
            end
        end

        // port one writes follow the init sequence, then the mask
        if (writeRise && pinNow.host.portSelect == PORT_HIGH) begin
            case (initSt_q)
                WAIT_TWO: begin
                    wordTwo_d = wData;
                    if (!wordOne_q[IW1_SINGLE]) begin
                        initSt_d = WAIT_THREE;
                    end else if (wordOne_q[IW1_NEED_FOUR]) begin
                        initSt_d = WAIT_FOUR;
                    end else begin
                        initSt_d = INIT_READY;
                    end
                end
                WAIT_THREE: begin
                    wordThree_d = wData;
                    initSt_d = wordOne_q[IW1_NEED_FOUR] ? WAIT_FOUR
                                                        : INIT_READY;
                end
                WAIT_FOUR: begin
                    wordFour_d = wData;
                    initSt_d   = INIT_READY;
                end
                INIT_READY: maskReg_d = wData;
                default:    initSt_d  = INIT_READY;
            endcase
        end

        // poll read end acknowledges the level it reported
        if (readRise && pinNow.host.portSelect == PORT_LOW
            && readSel_q[RS_POLL]) begin
            readSel_d[RS_POLL] = 1'b0;
            if (reqValid) begin
                svcSet[reqLevel]  = 1'b1;
                pendClr[reqLevel] = 1'b1;
            end
        end

        // acknowledge falling edges: freeze level, mark in-service
        if (ackFall) begin
            if (ackStep_q == STEP_RESET) begin
                ackLevel_d = reqValid ? reqLevel : DEFAULT_LEVEL;
                ackOwned_d = single | isMaster;
            end else if (!single && !isMaster) begin
                ackOwned_d = addrMatch;
            end
            if ((wideHost && ackStep_q == STEP_RESET)
                || (!wideHost && ackStep_q == 2'h1)) begin
                if (ackOwned_d) begin
                    svcSet[ackStep_q == STEP_RESET ? ackLevel_d
                                                   : ackLevel_q] = 1'b1;
                    pendClr[ackStep_q == STEP_RESET ? ackLevel_d
                                                    : ackLevel_q] = 1'b1;
                end
            end
        end

        // acknowledge rising edges: advance, auto end on the last one
        if (ackRise) begin
            if (ackStep_q >= lastStep) begin
                ackStep_d = STEP_RESET;
                if (wordFour_q[IW4_AUTO_END] && ackOwned_q) begin
                    svcClr[ackLevel_q] = 1'b1;
                end
            end else begin
                ackStep_d = ackStep_q + 2'h1;
            end
        end

        // a new request or service mark wins over a same-cycle clear
        pendReg_d = (pendReg_q & ~pendClr) | reqSet;
        svcReg_d  = (svcReg_q & ~svcClr) | svcSet;
    end

    // ======================================================================
    // pin drive: data bus, alert, chain id and role pin
    always_comb begin
        logic [7:0] ackByte;
        logic       ackDrive;
        ackByte  = CALL_OPCODE;
        ackDrive = 1'b0;
        // byte for the current acknowledge step
        if (wideHost) begin
            ackByte  = {wordTwo_q[7:3], ackLevel_q};
            ackDrive = (ackStep_q == 2'h1);
        end else begin
            case (ackStep_q)
                2'h0: ackByte = CALL_OPCODE;
                2'h1: ackByte = wordOne_q[IW1_STEP_FOUR]
                                ? {wordOne_q[7:5], ackLevel_q, 2'b00}
                                : {wordOne_q[7:6], ackLevel_q, 3'b000};
                default: ackByte = wordTwo_q;
            endcase
            ackDrive = 1'b1;
        end
        // master hands vector bytes to the addressed slave
        if (ackStep_q != STEP_RESET && (slaveAtLevel || !ackOwned_q)) begin
            ackDrive = 1'b0;
        end
        if (ackStep_q == STEP_RESET && !wideHost && !single && !isMaster) begin
            ackDrive = 1'b0;      // slave does not issue the call opcode
        end

        dataOut_d = dataOut_q;
        dataOe_d  = 1'b0;
        if (ackLow) begin
            dataOut_d = ackByte;
            dataOe_d  = ackDrive;
        end else if (readLow) begin
            dataOe_d = 1'b1;
            if (pinNow.host.portSelect == PORT_HIGH) begin
                dataOut_d = maskReg_q;
            end else if (readSel_q[RS_POLL]) begin
                dataOut_d = {reqValid, 4'h0, reqLevel};
            end else if (readSel_q[RS_IN_SERVICE]) begin
                dataOut_d = svcReg_q;
            end else begin
                dataOut_d = pendReg_q;
            end
        end

        // alert while a request qualifies and no sequence runs
        alert_d = reqValid && initSt_q == INIT_READY
                  && ackStep_q == STEP_RESET && !ackLow;

        // chain id: outputs for master or single, inputs for slave
        casOe_d  = single | isMaster;
        casOut_d = (slaveAtLevel && (ackLow || ackStep_q != STEP_RESET))
                   ? ackLevel_q : 3'h0;

        // role pin: transceiver enable (low active) when buffered
        roleOe_d  = buffered;
        roleOut_d = ~dataOe_d;
    end

    // ======================================================================
    // registers
    always_ff @(posedge ref_clk or negedge nrst) begin
        if (!nrst) begin
            initSt_q    <= INIT_READY;
            wordOne_q   <= WORD_RESET;
            wordTwo_q   <= WORD_RESET;
            wordThree_q <= WORD_RESET;
            wordFour_q  <= WORD_RESET;
            maskReg_q   <= WORD_RESET;
            pendReg_q   <= WORD_RESET;
            svcReg_q    <= WORD_RESET;
            readSel_q   <= SEL_RESET;
            ackStep_q   <= STEP_RESET;
            ackLevel_q  <= DEFAULT_LEVEL;
            ackOwned_q  <= 1'b0;
            reqPrev_q   <= 8'hFF;  // lines idle high behind pull-ups
            ackPrev_q   <= 1'b1;   // strobes idle high
            readPrev_q  <= 1'b1;
            writePrev_q <= 1'b1;
            dataOut_q   <= WORD_RESET;
            dataOe_q    <= 1'b0;
            alert_q     <= 1'b0;
            casOut_q    <= 3'h0;
            casOe_q     <= 1'b0;
            roleOut_q   <= 1'b1;
            roleOe_q    <= 1'b0;
        end else begin
            initSt_q    <= initSt_d;
            wordOne_q   <= wordOne_d;
            wordTwo_q   <= wordTwo_d;
            wordThree_q <= wordThree_d;
            wordFour_q  <= wordFour_d;
            maskReg_q   <= maskReg_d;
            pendReg_q   <= pendReg_d;
            svcReg_q    <= svcReg_d;
            readSel_q   <= readSel_d;
            ackStep_q   <= ackStep_d;
            ackLevel_q  <= ackLevel_d;
            ackOwned_q  <= ackOwned_d;
            reqPrev_q   <= pinNow.serviceReqLine;
            ackPrev_q   <= pinNow.host.cpuAckN;
            readPrev_q  <= pinNow.host.readN;
            writePrev_q <= pinNow.host.writeN;
            dataOut_q   <= dataOut_d;
            dataOe_q    <= dataOe_d;
            alert_q     <= alert_d;
            casOut_q    <= casOut_d;
            casOe_q     <= casOe_d;
            roleOut_q   <= roleOut_d;
            roleOe_q    <= roleOe_d;
        end
    end

    // outputs straight from flops
    assign hostDataOut = dataOut_q;
    assign hostDataOe  = dataOe_q;
    assign cpuAlertOut = alert_q;
    assign chainIdOut  = casOut_q;
    assign chainIdOe   = casOe_q;
    assign roleOut     = roleOut_q;
    assign roleOe      = roleOe_q;
endmodule // ipc_top
`default_nettype wire

// >>> verification/ipc_assertions.sv
/* pin-level checks of ipc_top, one clock domain.
   assumes the bind below; pin to pin latency of three edges. */
`timescale 1ns/1ps
`default_nettype none
module ipc_assertions (
    input wire logic                  ref_clk,
    input wire logic                  nrst,
    input wire ipc_pkg::ipcHostPins_t hostPins,
    input wire logic                  hostDataOe,
    input wire logic                  cpuAlertOut,
    input wire logic                  roleOut,
    input wire logic                  roleOe
);
    import ipc_pkg::*;
    // ======================================================================
    // strobe aliases; windows span the sync plus output flop delay
    wire logic cs = hostPins.chipSelectN;
    wire logic rd = hostPins.readN;
    wire logic wr = hostPins.writeN;
    wire logic ack = hostPins.cpuAckN;
    wire logic want = (!rd && !cs) || !ack;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!nrst);
    property p_float; (cs && ack) [*4] |-> !hostDataOe; endproperty
    a_float: assert property (p_float)
        else $error("data lines driven while deselected");
    property p_read; (!cs && !rd && wr && ack) [*4] |-> hostDataOe; endproperty
    a_read: assert property (p_read)
        else $error("read not answered");
    property p_both; (!rd && !wr && ack) [*4] |-> !hostDataOe; endproperty
    a_both: assert property (p_both)
        else $error("drive during read and write together");
    property p_role; roleOe |-> roleOut == !hostDataOe; endproperty
    a_role: assert property (p_role)
        else $error("transceiver enable disagrees with drive");
    property p_ackq; !ack [*5] |-> !cpuAlertOut; endproperty
    a_ackq: assert property (p_ackq)
        else $error("alert held through acknowledge");
    property p_rise; $rose(hostDataOe) |-> $past(want, 3); endproperty
    a_rise: assert property (p_rise)
        else $error("drive began without a strobe");
    property p_fall; $fell(hostDataOe) |-> !$past(want, 3); endproperty
    a_fall: assert property (p_fall)
        else $error("drive ended while strobe low");
    property p_alert; $rose(cpuAlertOut) |-> $past(ack, 3); endproperty
    a_alert: assert property (p_alert)
        else $error("alert rose inside acknowledge");
endmodule // ipc_assertions
bind ipc_top ipc_assertions i_chk (.ref_clk, .nrst, .hostPins, .hostDataOe,
    .cpuAlertOut, .roleOut, .roleOe);
`default_nettype wire

// >>> verification/ipc_cpu_model.sv
/* processor side: strobes, port select and data lines of the host bus.
   assumes callers step it on falling edges of ref_clk. */
`timescale 1ns/1ps
`default_nettype none
module ipc_cpu_model (
    input  wire logic             ref_clk,
    input  wire logic [7:0]       dutData,
    input  wire logic             dutOe,
    output ipc_pkg::ipcHostPins_t pins
);
    import ipc_pkg::*;
    logic       cs, rd, wr, ack, ps, drvOn;
    logic [7:0] drv, last;
    initial {cs, rd, wr, ack, ps, drvOn, drv, last} = {5'h1E, 1'b0, 16'h0000};
    // ======================================================================
    // a released bus toggles so a stale byte cannot pass as an answer
    assign pins = '{cs, rd, wr, ps, ack, drvOn ? drv : dutOe ? dutData : ~last};
    always @(posedge ref_clk) last <= pins.hostDataIn;
    // one pulse {cs,rd,wr,ack}; cs, data and port outlive the strobe
    task automatic pulse(input logic [3:0] s, input logic p,
                         input logic [7:0] d, output logic [7:0] q,
                         output logic oe);
        @(negedge ref_clk);
        {cs, rd, wr, ack} = s;
        ps = p;
        drv = d;
        drvOn = !s[1];
        repeat (6) @(negedge ref_clk);
        q = dutData;
        oe = dutOe;
        {rd, wr, ack} = 3'h7;
        @(negedge ref_clk);
        cs = 1'b1;
        drvOn = 1'b0;
        repeat (5) @(negedge ref_clk);
    endtask
endmodule // ipc_cpu_model
`default_nettype wire

// >>> verification/interrupt_ctrl_host_port_tb_top.sv
/* self-checking bench of ipc_top driven through the cpu model.
   assumes nothing outside; makes its own 25 MHz clock and reset. */
`timescale 1ns/1ps
`default_nettype none
module interrupt_ctrl_host_port_tb_top;
    import ipc_pkg::*;
    logic ref_clk = 0, nrst = 0, oe, dOe, alert, rOut, rOe, cOe;
    logic [2:0] cOut;
    logic [7:0] req = 8'h00, q, dOut;
    ipcHostPins_t pins;
    int err_count = 0, num_checks = 0, cyc = 0;
    always #20 ref_clk = ~ref_clk;
    ipc_cpu_model i_cpu (.ref_clk, .dutData(dOut), .dutOe(dOe), .pins);
    ipc_top i_dut (.ref_clk, .nrst, .hostPins(pins), .serviceReqLine(req),
        .chainIdIn(3'h0), .roleIn(1'b1), .hostDataOut(dOut), .hostDataOe(dOe),
        .cpuAlertOut(alert), .chainIdOut(cOut), .chainIdOe(cOe), .roleOut(rOut),
        .roleOe(rOe));
    // ======================================================================
    // helpers; an undriven bus reads as the inverse of the wanted byte
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        num_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic p, input logic [7:0] d);
        i_cpu.pulse(4'h5, p, d, q, oe);
    endtask
    task automatic rd(input logic p, input logic [7:0] exp);
        i_cpu.pulse(4'h3, p, 8'h00, q, oe);
        check(oe ? q : ~exp, exp);
    endtask
    task automatic ack(input logic [7:0] exp);
        i_cpu.pulse(4'hE, 1'b0, 8'h00, q, oe);
        check(oe ? q : ~exp, exp);
    endtask
    task automatic summarize;
        $display("checks %0d errors %0d", num_checks, err_count);
        if (err_count == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 2000) begin
            err_count++;
            summarize;
        end
    end
    // ======================================================================
    // scenarios: init, guards, request capture, acknowledge and end
    task automatic t_init;
        check({dOe, alert, rOut}, 8'h01);
        wr(1'b0, 8'h17);
        wr(1'b1, 8'h20);
        wr(1'b1, 8'h0C);
        check({7'h00, rOe}, 8'h01);
        check({4'h0, cOut, cOe}, 8'h01);
        wr(1'b1, 8'hF0);
        rd(1'b1, 8'hF0);
    endtask
    task automatic t_guard;
        i_cpu.pulse(4'hB, 1'b1, 8'h00, q, oe);
        check({7'h00, oe}, 8'h00);
        i_cpu.pulse(4'h1, 1'b1, 8'hFF, q, oe);
        check({7'h00, oe}, 8'h00);
        rd(1'b1, 8'hF0);
    endtask
    task automatic t_req;
        wr(1'b0, 8'h0A);
        req = 8'h24;
        repeat (8) @(negedge ref_clk);
        check({7'h00, alert}, 8'h01);
        rd(1'b0, 8'h24);
    endtask
    task automatic t_ack;
        ack(CALL_OPCODE);
        ack(8'h08);
        ack(8'h20);
        check({7'h00, alert}, 8'h00);
        rd(1'b0, 8'h20);
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h04);
        wr(1'b0, 8'h20);
        rd(1'b0, 8'h00);
    endtask
    // level mode, sixteen-bit host, auto end, then a poll read
    task automatic t_wide;
        wr(1'b0, 8'h1B);
        wr(1'b1, 8'h40);
        wr(1'b1, 8'h03);
        i_cpu.pulse(4'hE, 1'b0, 8'h00, q, oe);
        check({7'h00, oe}, 8'h00);
        ack(8'h42);
        rd(1'b0, 8'h24);
        wr(1'b0, 8'h0B);
        rd(1'b0, 8'h00);
        wr(1'b0, 8'h0C);
        rd(1'b0, 8'h82);
        rd(1'b0, 8'h04);
    endtask
    initial begin
        repeat (10) @(negedge ref_clk);
        nrst = 1'b1;
        t_init;
        t_guard;
        t_req;
        t_ack;
        t_wide;
        summarize;
    end
endmodule // interrupt_ctrl_host_port_tb_top
`default_nettype wire
